/* include/pmsc_consts.svh */
// constants of the system control block: offsets, fields, resets, timing
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH
`define PMSC_CLK_MHZ 125
`define PMSC_WARN_US 900
`define PMSC_USBRST_US 100
`define PMSC_DEBOUNCE_US 30000
`define PMSC_TASK_CYC 64
`define PMSC_DIE_HOT_C 8'h6E
`define PMSC_NUM_PAGES 5
`define PMSC_OFF_CTRL 8'h00
`define PMSC_OFF_STATUS 8'h04
`define PMSC_OFF_BATTHR 8'h08
`define PMSC_OFF_GPIO 8'h0C
`define PMSC_OFF_PAGE 8'h10
`define PMSC_OFF_PDATA 8'h14
`define PMSC_OFF_COIN 8'h18
`define PMSC_CTRL_SOFTRST 0
`define PMSC_CTRL_ALT 1
`define PMSC_CTRL_USBRST 2
`define PMSC_CTRL_SDON 3
`define PMSC_CTRL_OFFREQ 4
`define PMSC_ST_UV 3
`define PMSC_ST_TRIP 4
`define PMSC_ST_HOT 5
`define PMSC_ST_UIBTN 6
`define PMSC_ST_PWRBTN 7
`define PMSC_ST_UIEDGE 8
`define PMSC_BATTHR_RST 10'h200
`define PMSC_COIN_RST 8'h00
`define PMSC_FAST_INIT 9'h001
`define PMSC_SLOW_INIT 2'h3
`endif

/* include/pmsc_pkg.sv */
// types of the system control block
package pmsc_pkg;
   typedef enum logic [2:0] {
      ST_RESET = 3'h0,
      ST_OTP = 3'h1,
      ST_EEPROM = 3'h3,
      ST_SUPPLY_INVALID = 3'h2,
      ST_POWER_DOWN = 3'h6,
      ST_ACTIVE = 3'h7,
      ST_TASK_OFF = 3'h5,
      ST_WARN = 3'h4
   } pmsc_state_type;
endpackage

/* include/pmsc_pin_if.sv */
// pin bundle between the input filter and its user
`timescale 1ns/10ps
interface pmsc_pin_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport filter(input raw, output level, rise, fall);
   modport user(output raw, input level, rise, fall);
endinterface

/* src/pmsc_pin_filter.sv */
// three-stage synchroniser with optional debounce and edge pulses
`timescale 1ns/10ps
module pmsc_pin_filter #(
   parameter int W = 1,
   parameter int DEB_CYC = 0,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic reset,
   pmsc_pin_if.filter pins
);
   localparam int CW = (DEB_CYC > 1) ? $clog2(DEB_CYC + 1) : 1;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
      logic [W-1:0][CW-1:0] cnt;
   } pmsc_filt_state_type;
   pmsc_filt_state_type st;
   pmsc_filt_state_type next_st;
   logic [W-1:0] unsettled;

   assign unsettled = st.s2 ^ st.s3;

   // s1 feeds s2 only; decisions look at s2 and s3
   always_comb begin
      next_st = st;
      next_st.s1 = pins.raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.rise = '0;
      next_st.fall = '0;
      for (int i = 0; i < W; i++) begin
         if (st.s2[i] == st.s3[i] && st.s3[i] != st.level[i]) begin
            if (int'(st.cnt[i]) >= DEB_CYC) begin
               next_st.level[i] = st.s3[i];
               next_st.rise[i] = st.s3[i];
               next_st.fall[i] = ~st.s3[i];
               next_st.cnt[i] = '0;
            end else begin
               next_st.cnt[i] = st.cnt[i] + CW'(1);
            end
         end else begin
            // any bounce restarts the quiet-time count
            next_st.cnt[i] = '0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '{s1: INIT, s2: INIT, s3: INIT, level: INIT, rise: '0, fall: '0, cnt: '0};
      end else begin
         st <= next_st;
      end
   end

   assign pins.level = st.level;
   assign pins.rise = st.rise;
   assign pins.fall = st.fall;

   // checked per bit: other bits may settle while one still bounces
   a_level_needs_agree: assert property (@(posedge ref_clk) disable iff (reset)
      (|unsettled) |=> ((st.level ^ $past(st.level)) & $past(unsettled)) == '0)
      else $error("filtered level moved while stages disagreed");
endmodule

/* src/pmsc_system_control.sv */
// system control and power state logic of the power management device
`timescale 1ns/10ps
`include "pmsc_consts.svh"
module pmsc_system_control #(
   parameter int WARN_CYC = `PMSC_WARN_US * `PMSC_CLK_MHZ,
   parameter int USBRST_CYC = `PMSC_USBRST_US * `PMSC_CLK_MHZ,
   parameter int DEBOUNCE_CYC = `PMSC_DEBOUNCE_US * `PMSC_CLK_MHZ,
   parameter int TASK_CYC = `PMSC_TASK_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic coin_reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic host_thermal_trip_n,
   input wire logic host_platform_reset_n,
   input wire logic sd_card_low_volt_select,
   input wire logic supply_good,
   input wire logic supply_undervolt,
   input wire logic critical_event,
   input wire logic wake_event,
   input wire logic ui_button_in_n,
   input wire logic power_button_n,
   input wire logic [7:0] die_temp,
   input wire logic battery_temp_alert,
   input wire logic system_temp_alert,
   input wire logic [9:0] battery_voltage,
   input wire logic otp_ready,
   input wire logic [39:0] otp_image,
   input wire logic eeprom_present,
   input wire logic eeprom_ready,
   input wire logic [39:0] eeprom_image,
   input wire logic [1:0] gpio_lv_in,
   output logic [1:0] gpio_lv_out,
   output logic [1:0] gpio_lv_oe,
   output logic battery_id_in,
   input wire logic battery_id_out,
   output logic rails_on,
   output logic resume_reset_n,
   output logic core_power_good,
   output logic processor_hot_alert_n,
   output logic sd_card_power_enable_n,
   output logic sd_supply_1v8,
   output logic shutdown_warning_n,
   output logic usb_phy_reset_n,
   output logic undervoltage_flag
);
   typedef struct packed {
      pmsc_pkg::pmsc_state_type state;
      logic [23:0] timer;
      logic [15:0] usb_tmr;
      logic usb_rst;
      logic to_invalid;
      logic alt;
      logic sd_on;
      logic uv_flag;
      logic trip_flag;
      logic edge_flag;
      logic hot;
      logic sd_1v8;
      logic ee_done;
      logic [9:0] batthr;
      logic [1:0] gpio_out;
      logic [1:0] gpio_oe;
      logic [2:0] page;
      logic [`PMSC_NUM_PAGES-1:0][7:0] pages;
      logic ack;
      logic [31:0] rdata;
   } pmsc_ctl_state_type;

   pmsc_ctl_state_type st;
   pmsc_ctl_state_type next_st;
   logic [7:0] coin_reg;
   logic trip_armed;
   logic trip_evt;
   logic hot_valid;
   logic alert;
   logic pwr_up;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_mux;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   pmsc_pin_if #(.W(9)) fast ();
   pmsc_pin_if #(.W(2)) slow ();
   assign fast.raw = {gpio_lv_in, wake_event, critical_event, supply_undervolt,
                      supply_good, sd_card_low_volt_select, host_platform_reset_n,
                      host_thermal_trip_n};
   assign slow.raw = {power_button_n, ui_button_in_n};

   pmsc_pin_filter #(.W(9), .DEB_CYC(0), .INIT(`PMSC_FAST_INIT)) u_fast (
      .ref_clk(ref_clk),
      .reset(reset),
      .pins(fast)
   );
   pmsc_pin_filter #(.W(2), .DEB_CYC(DEBOUNCE_CYC), .INIT(`PMSC_SLOW_INIT)) u_slow (
      .ref_clk(ref_clk),
      .reset(reset),
      .pins(slow)
   );

   assign pwr_up = (st.state == pmsc_pkg::ST_ACTIVE);
   assign rails_on = pwr_up || st.state == pmsc_pkg::ST_TASK_OFF ||
                     st.state == pmsc_pkg::ST_WARN;
   assign resume_reset_n = rails_on;
   assign core_power_good = pwr_up;
   // platform reset level only trusted once the resume reset is released
   assign trip_armed = resume_reset_n && fast.level[1];
   assign trip_evt = pwr_up && trip_armed && fast.fall[0];
   assign hot_valid = resume_reset_n && fast.level[1];
   assign alert = (die_temp > `PMSC_DIE_HOT_C) || battery_temp_alert ||
                  system_temp_alert || (battery_voltage <= st.batthr);
   assign wr_go = avs_write && st.ack;
   assign rd_go = avs_read && !st.ack;

   always_comb begin
      rd_mux = 32'h00000000;
      if (hit(avs_address, `PMSC_OFF_CTRL)) begin
         rd_mux[`PMSC_CTRL_ALT] = st.alt;
         rd_mux[`PMSC_CTRL_SDON] = st.sd_on;
      end else if (hit(avs_address, `PMSC_OFF_STATUS)) begin
         rd_mux[2:0] = st.state;
         rd_mux[`PMSC_ST_UV] = st.uv_flag;
         rd_mux[`PMSC_ST_TRIP] = st.trip_flag;
         rd_mux[`PMSC_ST_HOT] = st.hot;
         rd_mux[`PMSC_ST_UIBTN] = slow.level[0];
         rd_mux[`PMSC_ST_PWRBTN] = slow.level[1];
         rd_mux[`PMSC_ST_UIEDGE] = st.edge_flag;
      end else if (hit(avs_address, `PMSC_OFF_BATTHR)) begin
         rd_mux[9:0] = st.batthr;
      end else if (hit(avs_address, `PMSC_OFF_GPIO)) begin
         rd_mux[3:0] = {st.gpio_oe, st.gpio_out};
         rd_mux[5:4] = fast.level[8:7];
      end else if (hit(avs_address, `PMSC_OFF_PAGE)) begin
         rd_mux[2:0] = st.page;
      end else if (hit(avs_address, `PMSC_OFF_PDATA)) begin
         if (st.page < 3'(`PMSC_NUM_PAGES)) begin
            rd_mux[7:0] = st.pages[st.page];
         end
      end else if (hit(avs_address, `PMSC_OFF_COIN)) begin
         rd_mux[7:0] = coin_reg;
      end
   end

   always_comb begin
      next_st = st;
      next_st.ack = (avs_read || avs_write) && !st.ack;
      if (rd_go) begin
         next_st.rdata = rd_mux;
      end
      if (st.timer != 24'h000000) begin
         next_st.timer = st.timer - 24'h000001;
      end
      // clears come first so a same-cycle event still sets the flag
      if (wr_go && hit(avs_address, `PMSC_OFF_STATUS)) begin
         if (avs_writedata[`PMSC_ST_UV]) next_st.uv_flag = 1'b0;
         if (avs_writedata[`PMSC_ST_TRIP]) next_st.trip_flag = 1'b0;
         if (avs_writedata[`PMSC_ST_UIEDGE]) next_st.edge_flag = 1'b0;
      end
      if (wr_go && hit(avs_address, `PMSC_OFF_CTRL)) begin
         next_st.alt = avs_writedata[`PMSC_CTRL_ALT];
         next_st.sd_on = avs_writedata[`PMSC_CTRL_SDON];
      end
      if (wr_go && hit(avs_address, `PMSC_OFF_BATTHR)) next_st.batthr = avs_writedata[9:0];
      if (wr_go && hit(avs_address, `PMSC_OFF_GPIO)) begin
         next_st.gpio_out = avs_writedata[1:0];
         next_st.gpio_oe = avs_writedata[3:2];
      end
      if (wr_go && hit(avs_address, `PMSC_OFF_PAGE)) next_st.page = avs_writedata[2:0];
      // page 0 is left writable; guarding it is up to host software
      if (wr_go && hit(avs_address, `PMSC_OFF_PDATA) &&
          st.page < 3'(`PMSC_NUM_PAGES)) begin
         next_st.pages[st.page] = avs_writedata[7:0];
      end
      if (slow.rise[0] || slow.fall[0]) next_st.edge_flag = 1'b1;
      if (fast.rise[4]) next_st.uv_flag = 1'b1;
      next_st.hot = hot_valid && alert;
      if (resume_reset_n && core_power_good) begin
         next_st.sd_1v8 = fast.level[2];
      end
      // usb reset held a full pulse after its cause ends
      if (!pwr_up || (wr_go && hit(avs_address, `PMSC_OFF_CTRL) &&
          avs_writedata[`PMSC_CTRL_USBRST])) begin
         next_st.usb_tmr = 16'(USBRST_CYC - 1);
      end else if (st.usb_tmr != 16'h0000) begin
         next_st.usb_tmr = st.usb_tmr - 16'h0001;
      end
      next_st.usb_rst = !pwr_up || (st.usb_tmr != 16'h0000) ||
                        (wr_go && hit(avs_address, `PMSC_OFF_CTRL) &&
                         avs_writedata[`PMSC_CTRL_USBRST]);
      case (st.state)
         pmsc_pkg::ST_RESET: begin
            next_st.state = pmsc_pkg::ST_OTP;
         end
         pmsc_pkg::ST_OTP: begin
            if (otp_ready) begin
               next_st.pages = otp_image;
               next_st.state = pmsc_pkg::ST_EEPROM;
            end
         end
         pmsc_pkg::ST_EEPROM: begin
            if (st.ee_done || !eeprom_present) begin
               next_st.state = pmsc_pkg::ST_SUPPLY_INVALID;
            end else if (eeprom_ready) begin
               next_st.pages = eeprom_image;
               next_st.ee_done = 1'b1;
               next_st.state = pmsc_pkg::ST_SUPPLY_INVALID;
            end
         end
         pmsc_pkg::ST_SUPPLY_INVALID: begin
            if (fast.level[3] && !fast.level[4]) begin
               next_st.state = pmsc_pkg::ST_POWER_DOWN;
            end
         end
         pmsc_pkg::ST_POWER_DOWN: begin
            if (fast.level[4] || !fast.level[3]) begin
               next_st.state = pmsc_pkg::ST_SUPPLY_INVALID;
            end else if (fast.level[6]) begin
               next_st.state = pmsc_pkg::ST_ACTIVE;
            end
         end
         pmsc_pkg::ST_ACTIVE: begin
            if (trip_evt) begin
               next_st.trip_flag = 1'b1;
               next_st.state = pmsc_pkg::ST_POWER_DOWN;
            end else if (fast.level[4]) begin
               next_st.to_invalid = 1'b1;
               next_st.timer = 24'(TASK_CYC - 1);
               next_st.state = pmsc_pkg::ST_TASK_OFF;
            end else if (fast.level[5]) begin
               next_st.timer = 24'(WARN_CYC - 1);
               next_st.state = pmsc_pkg::ST_WARN;
            end else if (slow.fall[1] || (wr_go && hit(avs_address, `PMSC_OFF_CTRL) &&
                         avs_writedata[`PMSC_CTRL_OFFREQ])) begin
               next_st.to_invalid = 1'b0;
               next_st.timer = 24'(TASK_CYC - 1);
               next_st.state = pmsc_pkg::ST_TASK_OFF;
            end
         end
         pmsc_pkg::ST_TASK_OFF: begin
            if (st.timer == 24'h000000) begin
               next_st.state = st.to_invalid ? pmsc_pkg::ST_SUPPLY_INVALID
                                        : pmsc_pkg::ST_POWER_DOWN;
            end
         end
         pmsc_pkg::ST_WARN: begin
            if (st.timer == 24'h000000) begin
               next_st.state = pmsc_pkg::ST_POWER_DOWN;
            end
         end
         default: begin
            next_st.state = pmsc_pkg::ST_RESET;
         end
      endcase
      if (wr_go && hit(avs_address, `PMSC_OFF_CTRL) &&
          avs_writedata[`PMSC_CTRL_SOFTRST]) begin
         next_st.state = pmsc_pkg::ST_RESET;
      end
   end

   // core reset is the supply-derived power-on reset
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.state <= pmsc_pkg::ST_RESET;
         st.usb_rst <= 1'b1;
         st.batthr <= `PMSC_BATTHR_RST;
      end else begin
         st <= next_st;
      end
   end

   // kept apart from the core reset so the value outlives supply loss
   always_ff @(posedge ref_clk or posedge coin_reset) begin
      if (coin_reset) begin
         coin_reg <= `PMSC_COIN_RST;
      end else if (wr_go && hit(avs_address, `PMSC_OFF_COIN)) begin
         coin_reg <= avs_writedata[7:0];
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
   assign avs_readdata = st.rdata;
   assign processor_hot_alert_n = !st.hot;
   assign sd_card_power_enable_n = !(st.sd_on && resume_reset_n && core_power_good);
   assign sd_supply_1v8 = st.sd_1v8;
   assign shutdown_warning_n = !(st.state == pmsc_pkg::ST_TASK_OFF ||
                                 st.state == pmsc_pkg::ST_WARN);
   assign usb_phy_reset_n = !st.usb_rst;
   assign undervoltage_flag = st.uv_flag;
   // alternate use: pin 0 listens to the host, pin 1 talks back
   assign gpio_lv_oe = st.alt ? 2'h2 : st.gpio_oe;
   assign gpio_lv_out = st.alt ? {battery_id_out, 1'b0} : st.gpio_out;
   assign battery_id_in = st.alt && fast.level[7];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_trip_kills_rails: assert property (trip_evt && !fast.level[4] |=> !rails_on)
      else $error("rails still on after thermal trip");
   a_trip_disarmed: assert property (pwr_up && !trip_armed && !fast.level[4] &&
      !fast.level[5] && !slow.fall[1] && !avs_write |=> pwr_up)
      else $error("active state left while trip unarmed");
   a_hot_die_level: assert property (hot_valid && die_temp > `PMSC_DIE_HOT_C
      |=> !processor_hot_alert_n)
      else $error("processor hot missing above die alert");
   a_hot_invalid: assert property (!hot_valid |=> processor_hot_alert_n)
      else $error("processor hot driven while resets held");
   a_warn_hold: assert property (st.state == pmsc_pkg::ST_WARN && st.timer != 24'h000000
      && !avs_write |=> st.state == pmsc_pkg::ST_WARN && !shutdown_warning_n)
      else $error("shutdown warning ended early");
   a_task_warning: assert property (st.state == pmsc_pkg::ST_TASK_OFF
      |-> !shutdown_warning_n)
      else $error("no warning during power-down task list");
   a_usb_min_pulse: assert property (st.usb_tmr != 16'h0000 |=> !usb_phy_reset_n)
      else $error("usb reset released before minimum");
   a_wake_only: assert property (st.state == pmsc_pkg::ST_POWER_DOWN &&
      fast.level[6] && fast.level[3] && !fast.level[4] && !avs_write |=> pwr_up)
      else $error("wake ignored in power-down state");
   a_invalid_hold: assert property (st.state == pmsc_pkg::ST_SUPPLY_INVALID
      && !fast.level[3] && !avs_write |=> st.state == pmsc_pkg::ST_SUPPLY_INVALID)
      else $error("left supply-invalid without good supply");
   // the set wins over a same-cycle clear, so the flag must always follow the rise
   a_uv_flag_set: assert property (fast.rise[4] |=> undervoltage_flag)
      else $error("undervoltage flag not raised");
endmodule

/* test/pmsc_host_model.sv */
// host processor model: platform reset and thermal trip pins
`timescale 1ns/10ps
module pmsc_host_model (
   input wire logic ref_clk,
   input wire logic core_power_good,
   input wire logic hold_reset,
   input wire logic trip_req,
   output logic host_platform_reset_n,
   output logic host_thermal_trip_n
);
   logic [2:0] up_cnt;
   initial begin
      up_cnt = 3'h0;
      host_platform_reset_n = 1'b0;
      host_thermal_trip_n = 1'b1;
   end
   // host leaves reset only some cycles after core power is good
   always @(posedge ref_clk) begin
      if (!core_power_good || hold_reset) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
      host_platform_reset_n <= (up_cnt == 3'h7);
      host_thermal_trip_n <= !trip_req; // pulled up unless tripping
   end
endmodule

/* test/pmic_system_control_states_tb_top.sv */
// self-checking bench of the system control block
`timescale 1ns/10ps
module pmic_system_control_states_tb_top;
   logic ref_clk = 1'b0, reset = 1'b1, coin_reset = 1'b0;
   logic [7:0] avs_address = 8'h00, die_temp = 8'h20, cv;
   logic avs_read = 1'b0, avs_write = 1'b0, sd_sel = 1'b0, supply_good = 1'b0;
   logic supply_undervolt = 1'b0, critical_event = 1'b0, wake_event = 1'b0;
   logic ui_n = 1'b1, pwr_n = 1'b1, bat_alert = 1'b0, sys_alert = 1'b0, otp_ready = 1'b0;
   logic eeprom_present = 1'b1, eeprom_ready = 1'b1, bid_out = 1'b0;
   logic hold_rst = 1'b0, trip_req = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata, seed;
   logic [9:0] batt_v = 10'h300;
   logic [39:0] otp_image = 40'h0, eeprom_image = 40'h0;
   logic [1:0] gpio_in = 2'b00, gpio_out, gpio_oe;
   logic avs_waitrequest, bid_in, rails_on, rsm_n, cpg, hot_n, sd_en_n, sd_1v8;
   logic warn_n, usb_n, uv_flag, plt_n, trip_n;
   int fails = 0, n_compared = 0, k;
   always #4 ref_clk = ~ref_clk;
   pmsc_host_model host_u (.ref_clk(ref_clk), .core_power_good(cpg), .hold_reset(hold_rst),
      .trip_req(trip_req), .host_platform_reset_n(plt_n), .host_thermal_trip_n(trip_n));
   pmsc_system_control #(.WARN_CYC(40), .USBRST_CYC(20), .DEBOUNCE_CYC(8), .TASK_CYC(8)) dut_u (
      .ref_clk(ref_clk), .reset(reset), .coin_reset(coin_reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .host_thermal_trip_n(trip_n), .host_platform_reset_n(plt_n),
      .sd_card_low_volt_select(sd_sel), .supply_good(supply_good),
      .supply_undervolt(supply_undervolt), .critical_event(critical_event),
      .wake_event(wake_event), .ui_button_in_n(ui_n), .power_button_n(pwr_n),
      .die_temp(die_temp), .battery_temp_alert(bat_alert), .system_temp_alert(sys_alert),
      .battery_voltage(batt_v), .otp_ready(otp_ready), .otp_image(otp_image),
      .eeprom_present(eeprom_present), .eeprom_ready(eeprom_ready),
      .eeprom_image(eeprom_image), .gpio_lv_in(gpio_in), .gpio_lv_out(gpio_out),
      .gpio_lv_oe(gpio_oe), .battery_id_in(bid_in), .battery_id_out(bid_out),
      .rails_on(rails_on), .resume_reset_n(rsm_n), .core_power_good(cpg),
      .processor_hot_alert_n(hot_n), .sd_card_power_enable_n(sd_en_n),
      .sd_supply_1v8(sd_1v8), .shutdown_warning_n(warn_n), .usb_phy_reset_n(usb_n),
      .undervoltage_flag(uv_flag));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_hot(logic [7:0] t, logic [9:0] v, logic ba, logic sa);
      return (t > 8'h6E) || ba || sa || (v <= 10'h200);
   endfunction
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) fails++;
   endtask
   task automatic wst(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'h04, 32'h0);
         n++;
      end while (rdata[2:0] !== s && n < 300);
      chk("state", {29'h0, s}, {29'h0, rdata[2:0]});
   endtask
   // counts cycles with the chosen pin low while rails are still on
   task automatic lows(input bit w, input int span, output int c);
      c = 0;
      repeat (span) begin
         @(posedge ref_clk);
         if ((w ? warn_n : usb_n) === 1'b0 && rails_on === 1'b1) c++;
      end
   endtask
   task automatic up;
      supply_good <= 1'b1;
      wst(3'h6);
      wake_event <= 1'b1;
      wst(3'h7);
      wake_event <= 1'b0;
      cyc(12);
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      end_of_test();
   end
   initial begin
      seed = lfsr(32'hF2C24DE1);
      otp_image = {seed[7:0], seed};
      eeprom_image = ~otp_image;
      cv = seed[15:8];
      cyc(4);
      chk("reset_pins", 32'h3, {28'h0, rails_on, usb_n, warn_n, hot_n});
      reset <= 1'b0;
      wst(3'h1);
      otp_ready <= 1'b1;
      wst(3'h2);
      // pages are only read, the sequence page is left untouched
      for (int p = 0; p < 6; p++) begin
         bus(1'b1, 8'h10, 32'(p));
         bus(1'b0, 8'h14, 32'h0);
         chk("page", p < 5 ? {24'h0, eeprom_image[8*p +: 8]} : 32'h0, rdata);
      end
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0, rdata);
      bus(1'b1, 8'h18, {24'h0, cv});
      wake_event <= 1'b1;
      cyc(20);
      wst(3'h2);
      wake_event <= 1'b0;
      up();
      $display("test bring_up done");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         die_temp <= i == 0 ? 8'h6E : i == 1 ? 8'h6F : i == 2 ? 8'h20 : seed[7:0];
         batt_v <= i == 0 ? 10'h201 : i == 2 ? 10'h200 : i < 3 ? 10'h300 : seed[17:8];
         bat_alert <= i > 2 && seed[20] && seed[21];
         sys_alert <= i > 2 && seed[22] && seed[23];
         cyc(5);
         chk("hot", {31'h0, !exp_hot(die_temp, batt_v, bat_alert, sys_alert)}, hot_n);
      end
      die_temp <= 8'h20;
      batt_v <= 10'h300;
      bat_alert <= 1'b0;
      sys_alert <= 1'b0;
      cyc(5);
      chk("hot_clear", 32'h1, hot_n);
      bus(1'b1, 8'h00, 32'h8);
      sd_sel <= 1'b1;
      cyc(8);
      chk("sd_on", 32'h1, {30'h0, sd_en_n, sd_1v8});
      sd_sel <= 1'b0;
      bus(1'b1, 8'h00, 32'hA);
      gpio_in <= 2'b01;
      bid_out <= 1'b1;
      cyc(8);
      chk("sd_3v3_batid", 32'h55, {25'h0, gpio_oe, gpio_out, rsm_n, sd_1v8, bid_in});
      $display("test pins done");
      bus(1'b1, 8'h00, 32'h4);
      lows(1'b0, 100, k);
      chk("usb_low", 32'd20, k);
      bus(1'b1, 8'h0C, 32'hE);
      cyc(1);
      chk("gpio", 32'hE, {28'h0, gpio_oe, gpio_out});
      ui_n <= 1'b0;
      cyc(3);
      ui_n <= 1'b1;
      cyc(30);
      bus(1'b0, 8'h04, 32'h0);
      chk("ui_glitch", 32'h0, {31'h0, rdata[8]});
      ui_n <= 1'b0;
      cyc(30);
      bus(1'b0, 8'h04, 32'h0);
      chk("ui_press", 32'h1, {31'h0, rdata[8]});
      ui_n <= 1'b1;
      $display("test usb_button done");
      hold_rst <= 1'b1;
      cyc(6);
      trip_req <= 1'b1;
      cyc(10);
      wst(3'h7);
      trip_req <= 1'b0;
      hold_rst <= 1'b0;
      cyc(16);
      trip_req <= 1'b1;
      lows(1'b1, 20, k);
      chk("trip_nowarn", 32'h0, {k[30:0], rails_on});
      bus(1'b0, 8'h04, 32'h0);
      chk("trip_flag", 32'h16, {27'h0, rdata[4:0]});
      trip_req <= 1'b0;
      up();
      critical_event <= 1'b1;
      lows(1'b1, 100, k);
      chk("warn_len", 32'd40, k);
      wst(3'h6);
      critical_event <= 1'b0;
      up();
      pwr_n <= 1'b0;
      lows(1'b1, 60, k);
      chk("task_warn", 32'd8, k);
      pwr_n <= 1'b1;
      wst(3'h6);
      up();
      supply_undervolt <= 1'b1;
      lows(1'b1, 60, k);
      chk("uv_warn", 32'd8, k);
      wst(3'h2);
      chk("uv_flag", 32'h1, uv_flag);
      supply_undervolt <= 1'b0;
      $display("test shutdowns done");
      bus(1'b1, 8'h00, 32'h1);
      wst(3'h6);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b0, 8'h14, 32'h0);
      chk("soft_otp", {24'h0, otp_image[15:8]}, rdata);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      wst(3'h6);
      bus(1'b0, 8'h18, 32'h0);
      chk("coin_keep", {24'h0, cv}, rdata);
      coin_reset <= 1'b1;
      cyc(2);
      coin_reset <= 1'b0;
      bus(1'b0, 8'h18, 32'h0);
      chk("coin_clear", 32'h0, rdata);
      $display("test resets done");
      end_of_test();
   end
endmodule
